// *** common/tdsl_cfg.svh ***
// tdsl_cfg.svh: register offsets, field positions, reset values, threshold scale
// assumes: included by bare name from the comparator, top and sim files
`ifndef TDSL_CFG_SVH
`define TDSL_CFG_SVH

`define TDSL_ADDR_W 6
`define TDSL_SAMPLE_W 16
`define TDSL_OFS_TAP_THRESHOLD 6'h1D
`define TDSL_OFS_TAP_DURATION 6'h21
`define TDSL_OFS_TAP_LATENCY 6'h22
`define TDSL_OFS_SECOND_WINDOW 6'h23
`define TDSL_OFS_TAP_AXIS_CTRL 6'h2A
`define TDSL_OFS_SOURCE_STATUS 6'h2B
`define TDSL_OFS_IRQ_ENABLE 6'h2E
`define TDSL_OFS_IRQ_SOURCE 6'h30
`define TDSL_REG_RESET 8'h00
// irq enable / source bit positions
`define TDSL_IRQ_DATA_READY 7
`define TDSL_IRQ_SINGLE_TAP 6
`define TDSL_IRQ_DOUBLE_TAP 5
`define TDSL_IRQ_ACTIVITY 4
`define TDSL_IRQ_INACTIVITY 3
`define TDSL_IRQ_FREE_FALL 2
`define TDSL_IRQ_WATERMARK 1
`define TDSL_IRQ_OVERRUN 0
// flags cleared by a source read, and by a data read
`define TDSL_CLR_ON_SRC_READ 8'h7C
`define TDSL_CLR_ON_DATA_READ 8'h83
// tap axis control fields
`define TDSL_AXIS_SUPPRESS 3
// source status fields
`define TDSL_STAT_ACT_LSB 4
`define TDSL_STAT_ASLEEP 3
`define TDSL_STAT_TAP_LSB 0
// threshold lsb sits this many bits above the sample lsb
`define TDSL_THR_SHIFT 4
`endif

// *** common/tdsl_pkg.sv ***
// tdsl_pkg: state types of the tap detector and the activity link
// assumes: compiled before every other tdsl file
package tdsl_pkg;

    typedef enum logic [2:0] {
        TDSL_TAP_IDLE,
        TDSL_TAP_FIRST,
        TDSL_TAP_LATENCY,
        TDSL_TAP_WINDOW,
        TDSL_TAP_SECOND,
        TDSL_TAP_WAIT_LOW
    } tdsl_tap_state_t;

    typedef enum logic {
        TDSL_SEEK_INACTIVITY,
        TDSL_SEEK_ACTIVITY
    } tdsl_link_state_t;

endpackage : tdsl_pkg

// *** common/tdsl_core_if.sv ***
// tdsl_core_if: carrier between the top and its comparator and link modules
// assumes: one clock; all members driven on clk_sys_i
`timescale 1ns/1ps
`default_nettype none
interface tdsl_core_if;
    logic [2:0] axis_hit;
    logic act_det;
    logic inact_det;
    logic link_en;
    logic autosleep_en;
    logic act_pending;
    logic act_evt;
    logic inact_evt;
    logic asleep;

    modport cmp_mp (output axis_hit);
    modport link_mp (input act_det, inact_det, link_en, autosleep_en, act_pending,
                     output act_evt, inact_evt, asleep);
    modport top_mp (input axis_hit, act_evt, inact_evt, asleep,
                    output act_det, inact_det, link_en, autosleep_en, act_pending);
endinterface : tdsl_core_if
`default_nettype wire

// *** src/tdsl_axis_cmp.sv ***
// tdsl_axis_cmp: per-axis magnitude against the tap threshold
// assumes: raw samples are two's complement and unfiltered
`timescale 1ns/1ps
`default_nettype none
`include "tdsl_cfg.svh"
module tdsl_axis_cmp
    import tdsl_pkg::*;
(
    // samples
    input wire logic [3*`TDSL_SAMPLE_W-1:0] samp_xyz_i,
    // control
    input wire logic [7:0] thr_i,
    input wire logic [2:0] axis_en_i,
    // result
    tdsl_core_if.cmp_mp core
);

    wire [`TDSL_SAMPLE_W-1:0] thr_scaled = {{(`TDSL_SAMPLE_W-8-`TDSL_THR_SHIFT){1'b0}},
                                            thr_i, {`TDSL_THR_SHIFT{1'b0}}};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_axis
            wire [`TDSL_SAMPLE_W-1:0] s = samp_xyz_i[g*`TDSL_SAMPLE_W +: `TDSL_SAMPLE_W];
            // magnitude of the most negative code wraps to itself, still huge
            wire [`TDSL_SAMPLE_W-1:0] mag = s[`TDSL_SAMPLE_W-1] ? (~s + 1'b1) : s;
            assign core.axis_hit[2-g] = axis_en_i[2-g] && (mag > thr_scaled);
        end
    endgenerate

endmodule : tdsl_axis_cmp
`default_nettype wire

// *** src/tdsl_act_link.sv ***
// tdsl_act_link: activity/inactivity alternation and autosleep interlock
// assumes: detector pulses arrive one cycle wide on the sample strobe
`timescale 1ns/1ps
`default_nettype none
module tdsl_act_link
    import tdsl_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // core carrier
    tdsl_core_if.link_mp core
);

    tdsl_link_state_t seek;
    logic asleep;

    wire seek_act = !core.link_en || (seek == TDSL_SEEK_ACTIVITY);
    wire seek_inact = !core.link_en || (seek == TDSL_SEEK_INACTIVITY);
    wire act_hit = core.act_det && seek_act;
    wire inact_hit = core.inact_det && seek_inact;
    // an uncleared activity flag holds the part awake
    wire go_sleep = inact_hit && core.link_en && core.autosleep_en && !core.act_pending;

    assign core.act_evt = act_hit;
    assign core.inact_evt = inact_hit;
    assign core.asleep = asleep;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            seek <= TDSL_SEEK_INACTIVITY;
            asleep <= 1'b0;
        end else begin
            if (inact_hit) begin
                seek <= TDSL_SEEK_ACTIVITY;
            end else if (act_hit) begin
                seek <= TDSL_SEEK_INACTIVITY;
            end
            if (act_hit || !core.autosleep_en) begin
                asleep <= 1'b0;
            end else if (go_sleep) begin
                asleep <= 1'b1;
            end
        end
    end

endmodule : tdsl_act_link
`default_nettype wire

// *** src/tdsl_top.sv ***
// tdsl_top: tap detection, activity link, sleep status and event flags
// assumes: samples and detector pulses come from logic on clk_sys_i;
// the register port is driven by the serial port logic on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "tdsl_cfg.svh"

module tdsl_top
    import tdsl_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // unfiltered samples at the internal rate
    input wire logic samp_tick_i,
    input wire logic [`TDSL_SAMPLE_W-1:0] samp_x_i,
    input wire logic [`TDSL_SAMPLE_W-1:0] samp_y_i,
    input wire logic [`TDSL_SAMPLE_W-1:0] samp_z_i,
    // upstream motion and data-path events
    input wire logic act_det_i,
    input wire logic [2:0] act_axis_i,
    input wire logic inact_det_i,
    input wire logic free_fall_i,
    input wire logic data_ready_i,
    input wire logic watermark_i,
    input wire logic overrun_i,
    input wire logic data_read_i,
    // loose control bits
    input wire logic link_en_i,
    input wire logic autosleep_en_i,
    // register port
    input wire logic [`TDSL_ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // status
    output logic irq_o,
    output logic asleep_o
);

    tdsl_core_if core ();

    // register storage
    logic [7:0] tap_threshold_level;
    logic [7:0] tap_duration_limit;
    logic [7:0] tap_latency_time;
    logic [7:0] second_tap_window;
    logic [7:0] tap_axis_control;
    logic [7:0] irq_enable_mask;
    logic [7:0] irq_source_flags;
    logic [2:0] act_axes;
    logic [2:0] tap_axes;

    // tap engine
    tdsl_tap_state_t tap_state;
    tdsl_tap_state_t next_tap_state;
    logic [8:0] tap_cnt;
    logic [8:0] next_tap_cnt;
    logic [2:0] first_axes;
    logic [2:0] next_first_axes;
    logic single_evt;
    logic double_evt;

    // register decode
    wire wr_thr = reg_wr_i && (reg_addr_i == `TDSL_OFS_TAP_THRESHOLD);
    wire wr_dur = reg_wr_i && (reg_addr_i == `TDSL_OFS_TAP_DURATION);
    wire wr_lat = reg_wr_i && (reg_addr_i == `TDSL_OFS_TAP_LATENCY);
    wire wr_win = reg_wr_i && (reg_addr_i == `TDSL_OFS_SECOND_WINDOW);
    wire wr_axes = reg_wr_i && (reg_addr_i == `TDSL_OFS_TAP_AXIS_CTRL);
    wire wr_ie = reg_wr_i && (reg_addr_i == `TDSL_OFS_IRQ_ENABLE);
    wire rd_src = reg_rd_i && (reg_addr_i == `TDSL_OFS_IRQ_SOURCE);

    wire [7:0] status_view = {1'b0, act_axes, core.asleep, tap_axes};

    wire [7:0] rd_mux =
        (reg_addr_i == `TDSL_OFS_TAP_THRESHOLD) ? tap_threshold_level :
        (reg_addr_i == `TDSL_OFS_TAP_DURATION) ? tap_duration_limit :
        (reg_addr_i == `TDSL_OFS_TAP_LATENCY) ? tap_latency_time :
        (reg_addr_i == `TDSL_OFS_SECOND_WINDOW) ? second_tap_window :
        (reg_addr_i == `TDSL_OFS_TAP_AXIS_CTRL) ? tap_axis_control :
        (reg_addr_i == `TDSL_OFS_SOURCE_STATUS) ? status_view :
        (reg_addr_i == `TDSL_OFS_IRQ_ENABLE) ? irq_enable_mask :
        (reg_addr_i == `TDSL_OFS_IRQ_SOURCE) ? irq_source_flags :
        8'h00;

    // comparator and link
    tdsl_axis_cmp u_cmp (
        .samp_xyz_i ({samp_z_i, samp_y_i, samp_x_i}),
        .thr_i (tap_threshold_level),
        .axis_en_i (tap_axis_control[2:0]),
        .core (core.cmp_mp)
    );

    tdsl_act_link u_link (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .core (core.link_mp)
    );

    assign core.act_det = act_det_i;
    assign core.inact_det = inact_det_i;
    assign core.link_en = link_en_i;
    assign core.autosleep_en = autosleep_en_i;
    assign core.act_pending = irq_source_flags[`TDSL_IRQ_ACTIVITY];

    // tap conditions, valid only on a sample tick
    wire present = |core.axis_hit;
    wire double_on = irq_enable_mask[`TDSL_IRQ_DOUBLE_TAP];
    // zero latency or window leaves the double tap disabled
    wire double_ready = double_on && (tap_latency_time != 8'h00)
                        && (second_tap_window != 8'h00);
    wire suppress = tap_axis_control[`TDSL_AXIS_SUPPRESS];
    wire [8:0] cnt_inc = tap_cnt + 9'h001;
    wire over_dur = (cnt_inc > {1'b0, tap_duration_limit});
    wire lat_done = (cnt_inc >= {1'b0, tap_latency_time});
    wire win_done = (cnt_inc >= {1'b0, second_tap_window});

    // tap sequencer
    always_comb begin
        next_tap_state = tap_state;
        next_tap_cnt = tap_cnt;
        next_first_axes = first_axes;
        single_evt = 1'b0;
        double_evt = 1'b0;
        if (samp_tick_i) begin
            unique case (tap_state)
                TDSL_TAP_IDLE: begin
                    if (present) begin
                        next_tap_state = TDSL_TAP_FIRST;
                        next_tap_cnt = 9'h001;
                        next_first_axes = core.axis_hit;
                    end
                end
                TDSL_TAP_FIRST: begin
                    if (present) begin
                        next_tap_cnt = cnt_inc;
                        if (over_dur) begin
                            next_tap_state = TDSL_TAP_WAIT_LOW;
                        end
                    end else if (double_ready) begin
                        next_tap_state = TDSL_TAP_LATENCY;
                        next_tap_cnt = 9'h000;
                    end else begin
                        single_evt = 1'b1;
                        next_tap_state = TDSL_TAP_IDLE;
                    end
                end
                TDSL_TAP_LATENCY: begin
                    next_tap_cnt = cnt_inc;
                    if (suppress && present) begin
                        single_evt = 1'b1;
                        next_tap_state = TDSL_TAP_WAIT_LOW;
                    end else if (lat_done) begin
                        next_tap_state = TDSL_TAP_WINDOW;
                        next_tap_cnt = 9'h000;
                    end
                end
                TDSL_TAP_WINDOW: begin
                    if (present && (tap_cnt == 9'h000)) begin
                        single_evt = 1'b1;
                        next_tap_state = TDSL_TAP_WAIT_LOW;
                    end else if (present) begin
                        next_tap_state = TDSL_TAP_SECOND;
                        next_tap_cnt = 9'h001;
                    end else if (win_done) begin
                        single_evt = 1'b1;
                        next_tap_state = TDSL_TAP_IDLE;
                    end else begin
                        next_tap_cnt = cnt_inc;
                    end
                end
                TDSL_TAP_SECOND: begin
                    if (present) begin
                        next_tap_cnt = cnt_inc;
                        if (over_dur) begin
                            single_evt = 1'b1;
                            next_tap_state = TDSL_TAP_WAIT_LOW;
                        end
                    end else begin
                        single_evt = 1'b1;
                        double_evt = 1'b1;
                        next_tap_state = TDSL_TAP_IDLE;
                    end
                end
                TDSL_TAP_WAIT_LOW: begin
                    if (!present) begin
                        next_tap_state = TDSL_TAP_IDLE;
                    end
                end
            endcase
        end
    end

    // flag set terms; set wins over any clear in the same cycle
    wire single_set = single_evt && irq_enable_mask[`TDSL_IRQ_SINGLE_TAP];
    wire double_set = double_evt && irq_enable_mask[`TDSL_IRQ_DOUBLE_TAP];
    wire act_set = core.act_evt && irq_enable_mask[`TDSL_IRQ_ACTIVITY];
    wire inact_set = core.inact_evt && irq_enable_mask[`TDSL_IRQ_INACTIVITY];
    wire ff_set = free_fall_i && irq_enable_mask[`TDSL_IRQ_FREE_FALL];
    // data-path flags set regardless of enable
    wire [7:0] flag_set = {data_ready_i, single_set, double_set, act_set,
                           inact_set, ff_set, watermark_i, overrun_i};
    wire [7:0] flag_clr = (rd_src ? `TDSL_CLR_ON_SRC_READ : 8'h00)
                          | (data_read_i ? `TDSL_CLR_ON_DATA_READ : 8'h00);
    wire [7:0] next_flags = (irq_source_flags & ~flag_clr) | flag_set;

    // sample-ready never raises the line while asleep
    wire [7:0] irq_gate = irq_enable_mask
                          & ~({core.asleep, 7'h00});
    wire next_irq = |(next_flags & irq_gate);

    // tap axis latch; only taps overwrite it, nothing clears it
    wire tap_report = single_set || double_set;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tap_threshold_level <= `TDSL_REG_RESET;
            tap_duration_limit <= `TDSL_REG_RESET;
            tap_latency_time <= `TDSL_REG_RESET;
            second_tap_window <= `TDSL_REG_RESET;
            tap_axis_control <= `TDSL_REG_RESET;
            irq_enable_mask <= `TDSL_REG_RESET;
        end else begin
            if (wr_thr) tap_threshold_level <= reg_wdata_i;
            if (wr_dur) tap_duration_limit <= reg_wdata_i;
            if (wr_lat) tap_latency_time <= reg_wdata_i;
            if (wr_win) second_tap_window <= reg_wdata_i;
            if (wr_axes) tap_axis_control <= reg_wdata_i;
            if (wr_ie) irq_enable_mask <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tap_state <= TDSL_TAP_IDLE;
            tap_cnt <= 9'h000;
            first_axes <= 3'h0;
        end else begin
            tap_state <= next_tap_state;
            tap_cnt <= next_tap_cnt;
            first_axes <= next_first_axes;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tap_axes <= 3'h0;
            act_axes <= 3'h0;
        end else begin
            if (tap_report) begin
                tap_axes <= first_axes;
            end
            if (act_set) begin
                act_axes <= act_axis_i;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_source_flags <= 8'h00;
            irq_o <= 1'b0;
        end else begin
            irq_source_flags <= next_flags;
            irq_o <= next_irq;
        end
    end

    // read data held until the next read
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 8'h00;
            asleep_o <= 1'b0;
        end else begin
            if (reg_rd_i) begin
                reg_rdata_o <= rd_mux;
            end
            asleep_o <= core.asleep;
        end
    end

endmodule : tdsl_top
`default_nettype wire

// *** sim/tdsl_host_model.sv ***
// tdsl_host_model: host side of the register port, byte writes and reads
// assumes: one access at a time, launched 1 ns after a rising edge
`timescale 1ns/1ps
`default_nettype none
`include "tdsl_cfg.svh"
module tdsl_host_model
    import tdsl_pkg::*;
(
    // clock
    input wire logic clk_sys_i,
    // register port toward the block
    output logic [`TDSL_ADDR_W-1:0] reg_addr_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_rd_o,
    input wire logic [7:0] reg_rdata_i
);
    // rate and low power selection live outside this block
    initial begin
        reg_addr_o = 6'h3F;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'hFF;
        reg_rd_o = 1'b0;
    end

    // idle bus shows the inverse, so stale values never look valid
    task automatic wr(input logic [`TDSL_ADDR_W-1:0] addr, input logic [7:0] data);
        @(posedge clk_sys_i) #1;
        reg_addr_o = addr;
        reg_wdata_o = data;
        reg_wr_o = 1'b1;
        @(posedge clk_sys_i) #1;
        reg_wr_o = 1'b0;
        reg_addr_o = ~addr;
        reg_wdata_o = ~data;
    endtask : wr

    task automatic rd(input logic [`TDSL_ADDR_W-1:0] addr, output logic [7:0] data);
        @(posedge clk_sys_i) #1;
        reg_addr_o = addr;
        reg_rd_o = 1'b1;
        @(posedge clk_sys_i) #1;
        data = reg_rdata_i;
        reg_rd_o = 1'b0;
        reg_addr_o = ~addr;
    endtask : rd
endmodule : tdsl_host_model
`default_nettype wire

// *** sim/tdsl_top_sva.sv ***
// tdsl_top_sva: port assertions for the tap detector and activity link
// assumes: bound to tdsl_top; the shadow mirrors accepted host writes
`timescale 1ns/1ps
`default_nettype none
`include "tdsl_cfg.svh"
module tdsl_top_sva
    import tdsl_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // events and control
    input wire logic samp_tick_i,
    input wire logic act_det_i,
    input wire logic inact_det_i,
    input wire logic free_fall_i,
    input wire logic link_en_i,
    input wire logic autosleep_en_i,
    // register port
    input wire logic [`TDSL_ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // status
    input wire logic irq_o,
    input wire logic asleep_o
);
    logic [7:0] shadow_q [0:63];
    logic [`TDSL_ADDR_W-1:0] rd_addr_q;
    wire logic addr_rw = reg_addr_i inside {`TDSL_OFS_TAP_THRESHOLD, `TDSL_OFS_TAP_DURATION,
        `TDSL_OFS_TAP_LATENCY, `TDSL_OFS_SECOND_WINDOW, `TDSL_OFS_TAP_AXIS_CTRL,
        `TDSL_OFS_IRQ_ENABLE};
    wire logic [7:0] en_q = shadow_q[`TDSL_OFS_IRQ_ENABLE];
    wire logic [7:0] axctl_q = shadow_q[`TDSL_OFS_TAP_AXIS_CTRL];
    wire logic src_rd = reg_rd_i && (reg_addr_i == `TDSL_OFS_IRQ_SOURCE);
    // no source of a flag cleared by a source read is active this cycle
    wire logic quiet = !(samp_tick_i || act_det_i || inact_det_i || free_fall_i);

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < 64; i++)
                shadow_q[i] <= `TDSL_REG_RESET;
            rd_addr_q <= '0;
        end else begin
            if (reg_wr_i && addr_rw)
                shadow_q[reg_addr_i] <= reg_wdata_i;
            if (reg_rd_i)
                rd_addr_q <= reg_addr_i;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    // flag sources silent for a span, so late sets cannot mask the clear
    sequence s_calm_src_rd;
        src_rd && quiet && $past(quiet) && $past(quiet, 2);
    endsequence
    sequence s_status_rd;
        (reg_rd_i && reg_addr_i == `TDSL_OFS_SOURCE_STATUS && $stable(asleep_o))
            ##1 $stable(asleep_o);
    endsequence

    AST_RW_READBACK: assert property (
        $past(reg_rd_i && !reg_wr_i && addr_rw) |-> reg_rdata_o == shadow_q[rd_addr_q])
        else $error("control register read back differs from last write");
    AST_SINGLE_ON_TICK: assert property (
        $rose(irq_o) && en_q == 8'h40 && $past(en_q) == 8'h40 |-> $past(samp_tick_i))
        else $error("single tap irq not one cycle after a sample tick");
    AST_EN_OFF_NO_IRQ: assert property (
        en_q == 8'h00 && $past(en_q) == 8'h00 |-> !irq_o)
        else $error("irq raised with every enable off");
    AST_AXES_OFF_NO_TAP: assert property (
        axctl_q[2:0] == 3'h0 && $past(axctl_q[2:0]) == 3'h0 && (en_q & 8'h9F) == 8'h00
        && $past(en_q) == en_q && !$past(irq_o) |-> !irq_o)
        else $error("tap irq raised with all axes excluded");
    AST_SLEEP_NEEDS_LINK: assert property (
        $rose(asleep_o) |-> $past(link_en_i) && $past(autosleep_en_i))
        else $error("sleep entered without link and autosleep");
    AST_STATUS_ASLEEP: assert property (
        s_status_rd |-> reg_rdata_o[`TDSL_STAT_ASLEEP] == asleep_o)
        else $error("status asleep bit differs from asleep output");
    AST_ASLEEP_NO_DRDY: assert property (
        asleep_o && $past(asleep_o) && en_q == 8'h80 && $past(en_q) == 8'h80 |-> !irq_o)
        else $error("sample ready irq raised while asleep");
    AST_SRC_READ_CLEARS: assert property (
        s_calm_src_rd ##2 s_calm_src_rd |=> (reg_rdata_o & `TDSL_CLR_ON_SRC_READ) == 8'h00)
        else $error("source read left motion flags set");
endmodule : tdsl_top_sva

bind tdsl_top tdsl_top_sva chk (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .samp_tick_i(samp_tick_i), .act_det_i(act_det_i), .inact_det_i(inact_det_i),
    .free_fall_i(free_fall_i), .link_en_i(link_en_i), .autosleep_en_i(autosleep_en_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .asleep_o(asleep_o));
`default_nettype wire

// *** sim/tdsl_top_test.sv ***
// tdsl_top_test: self-checking bench for taps, link, sleep and flags
// assumes: host model drives the register port; bench drives samples
`timescale 1ns/1ps
`default_nettype none
`include "tdsl_cfg.svh"
`define TB_CHECK(what, exp, got) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) begin \
            n_mismatch++; \
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
        end \
    end
module tdsl_top_test;
    import tdsl_pkg::*;
    // event vector: act, inact, free fall, ready, watermark, overrun, data read
    localparam logic [6:0] ACT = 7'h40, INACT = 7'h20, FF = 7'h10, DRD = 7'h01;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic samp_tick_i = 1'b0;
    logic [15:0] sx = 16'h0000, sy = 16'h0000, sz = 16'h0000;
    logic [6:0] ev = 7'h00;
    logic [2:0] act_axis = 3'h0;
    logic link_en = 1'b0, autosleep_en = 1'b0;
    wire logic [5:0] reg_addr;
    wire logic reg_wr, reg_rd, irq, asleep;
    wire logic [7:0] reg_wdata, reg_rdata;
    int n_mismatch = 0, n_checks = 0, cycles = 0;

    always #10 clk_sys_i = ~clk_sys_i;

    tdsl_top dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .samp_tick_i(samp_tick_i),
        .samp_x_i(sx), .samp_y_i(sy), .samp_z_i(sz), .act_det_i(ev[6]),
        .act_axis_i(act_axis), .inact_det_i(ev[5]), .free_fall_i(ev[4]),
        .data_ready_i(ev[3]), .watermark_i(ev[2]), .overrun_i(ev[1]), .data_read_i(ev[0]),
        .link_en_i(link_en), .autosleep_en_i(autosleep_en), .reg_addr_i(reg_addr),
        .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata), .irq_o(irq), .asleep_o(asleep));
    tdsl_host_model host (.clk_sys_i(clk_sys_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr),
        .reg_wdata_o(reg_wdata), .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata));

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    // P/N: x just above/below +-threshold, E: x at threshold, Y/Z: other axes
    task automatic taps(input string pat);
        for (int i = 0; i < pat.len(); i++) begin
            @(posedge clk_sys_i) #1;
            samp_tick_i = 1'b1;
            sx = (pat[i] == "P") ? 16'h0101 : (pat[i] == "N") ? 16'hFEFF :
                 (pat[i] == "E") ? 16'h0100 : 16'h0000;
            sy = (pat[i] == "Y") ? 16'h0101 : 16'h0000;
            sz = (pat[i] == "Z") ? 16'hFEFF : 16'h0000;
            @(posedge clk_sys_i) #1;
            samp_tick_i = 1'b0;
            sx = ~sx;
            sy = ~sy;
            sz = ~sz;
            repeat (2) @(posedge clk_sys_i) #1;
        end
    endtask : taps

    task automatic pulse(input logic [6:0] which);
        @(posedge clk_sys_i) #1;
        ev = which;
        @(posedge clk_sys_i) #1;
        ev = 7'h00;
        repeat (2) @(posedge clk_sys_i) #1;
    endtask : pulse

    // host services the source register; second read shows what survives
    task automatic check_src(input logic [7:0] exp);
        logic [7:0] d;
        host.rd(`TDSL_OFS_IRQ_SOURCE, d);
        `TB_CHECK("irq source", exp, d)
        host.rd(`TDSL_OFS_IRQ_SOURCE, d);
        `TB_CHECK("irq source after read", exp & `TDSL_CLR_ON_DATA_READ, d)
    endtask : check_src

    task automatic check_status(input logic [7:0] exp);
        logic [7:0] d;
        host.rd(`TDSL_OFS_SOURCE_STATUS, d);
        `TB_CHECK("source status", exp, d)
    endtask : check_status

    task automatic t_regs;
        logic [5:0] rw [6] = '{6'h1D, 6'h21, 6'h22, 6'h23, 6'h2A, 6'h2E};
        logic [7:0] d;
        for (int i = 0; i < 6; i++) begin
            host.rd(rw[i], d);
            `TB_CHECK("reset value", 8'h00, d)
            host.wr(rw[i], {2'h2, rw[i]});
            host.rd(rw[i], d);
            `TB_CHECK("read back", {2'h2, rw[i]}, d)
        end
        host.wr(`TDSL_OFS_SOURCE_STATUS, 8'hFF);
        host.wr(`TDSL_OFS_IRQ_SOURCE, 8'hFF);
        check_status(8'h00);
        check_src(8'h00);
        host.rd(6'h3F, d);
        `TB_CHECK("unmapped read", 8'h00, d)
    endtask : t_regs

    task automatic t_single;
        host.wr(`TDSL_OFS_TAP_THRESHOLD, 8'h10);
        host.wr(`TDSL_OFS_TAP_DURATION, 8'h02);
        host.wr(`TDSL_OFS_TAP_AXIS_CTRL, 8'h04);
        host.wr(`TDSL_OFS_IRQ_ENABLE, 8'h40);
        taps("PQ");
        `TB_CHECK("irq", 1'b1, irq)
        check_src(8'h40);
        check_status(8'h04);
        taps("NNQ");
        check_src(8'h40);
        taps("YQZQEQ");
        check_src(8'h00);
        taps("PPPQ");
        check_src(8'h00);
        host.wr(`TDSL_OFS_IRQ_ENABLE, 8'h00);
        taps("PQ");
        check_src(8'h00);
        host.wr(`TDSL_OFS_IRQ_ENABLE, 8'h40);
        host.wr(`TDSL_OFS_TAP_AXIS_CTRL, 8'h00);
        taps("PQNQ");
        check_src(8'h00);
    endtask : t_single

    task automatic t_double;
        host.wr(`TDSL_OFS_TAP_AXIS_CTRL, 8'h06);
        host.wr(`TDSL_OFS_TAP_LATENCY, 8'h02);
        host.wr(`TDSL_OFS_SECOND_WINDOW, 8'h08);
        host.wr(`TDSL_OFS_IRQ_ENABLE, 8'h60);
        taps("PQ");
        check_src(8'h00);
        taps("QQQQYQQ");
        check_src(8'h60);
        taps("PQQQQQQQQQQQQQ");
        check_src(8'h40);
    endtask : t_double

    task automatic t_cancel;
        host.wr(`TDSL_OFS_TAP_AXIS_CTRL, 8'h0C);
        taps("PQPQQQQPQQQQQQQQQQQQQ");
        check_src(8'h40);
        host.wr(`TDSL_OFS_TAP_AXIS_CTRL, 8'h04);
        taps("PQQPPQQQQQQQQQQQQQ");
        check_src(8'h40);
        taps("PQQQQPPPQQQQQQQQQQQQQ");
        check_src(8'h40);
    endtask : t_cancel

    task automatic t_link;
        host.wr(`TDSL_OFS_IRQ_ENABLE, 8'h9C);
        act_axis = 3'h2;
        pulse(ACT);
        check_src(8'h10);
        check_status(8'h24);
        link_en = 1'b1;
        autosleep_en = 1'b1;
        pulse(INACT);
        check_src(8'h08);
        `TB_CHECK("asleep", 1'b1, asleep)
        check_status(8'h2C);
        pulse(INACT);
        check_src(8'h00);
        host.wr(`TDSL_OFS_IRQ_ENABLE, 8'h80);
        pulse(7'h0E);
        `TB_CHECK("irq asleep", 1'b0, irq)
        check_src(8'h83);
        pulse(DRD);
        check_src(8'h00);
        host.wr(`TDSL_OFS_IRQ_ENABLE, 8'h9C);
        act_axis = 3'h1;
        pulse(ACT);
        `TB_CHECK("awake", 1'b0, asleep)
        pulse(INACT);
        `TB_CHECK("awake uncleared", 1'b0, asleep)
        check_src(8'h18);
        check_status(8'h14);
        pulse(ACT);
        check_src(8'h10);
        pulse(INACT);
        `TB_CHECK("asleep again", 1'b1, asleep)
        pulse(FF);
        check_src(8'h0C);
    endtask : t_link

    // whole run is a few hundred cycles; the ceiling leaves wide room
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    initial begin
        repeat (2) @(posedge clk_sys_i);
        #1 sys_rst_i = 1'b0;
        t_regs();
        t_single();
        t_double();
        t_cancel();
        t_link();
        end_of_test();
    end
endmodule : tdsl_top_test
`default_nettype wire
